// ---- inc/touch_pkg.sv ----
// touch_pkg: shared constants, types and pin groups of the touch panel pin control block.
// assumes a 20 MHz reference clock; every count below is derived from that rate.
//
// Function
// - key event low on permitted key press, high again when debounce scan ends
// - busy high for the whole keypad debounce scan
// - touch busy high from end of sampling until result MSB appears
// - serial output bits change on falling serial clock edge
// - select low and no result bits: serial output driven low
// - serial output high impedance while select stays high
// - serial input sampled on each rising serial clock edge
// - writes accepted only while select is low, host selects every write
// - pen event low on panel touch, only while select is high
// - pen interrupts disabled keeps pen event output high
// - device held in reset while active-low device reset is low
// - X measurement drives X+ and X-, leaves Y- open
// - Y measurement drives Y-, leaves X- open, X+ to converter
// - pressure drives X- and Y+, X+ first value, Y- second
// - pen waiting grounds Y-, X- and Y+ open, X+ pull-up on
// - 12-bit results at no more than 125 kHz sampling rate
package touch_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SAMPLE_NS = 1500;
    localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONVERT_NS = 4000;
    localparam int CONVERT_CYCLES = (CONVERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_RATE_KHZ = 125;
    localparam int MIN_PERIOD_NS = 1000000 / MAX_RATE_KHZ;
    localparam int MIN_PERIOD_CYCLES = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYCLES_DEF = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    // converter and command layout
    localparam int ADC_BITS = 12;
    localparam int CMD_BITS = 8;
    localparam int CMD_START_BIT = 7;
    localparam int CMD_MODE_LSB = 4;
    localparam int CMD_PEN_EN_BIT = 3;
    localparam int CMD_KEY_EN_BIT = 2;

    // measurement selected by a command
    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_X = 3'h1,
        MODE_Y = 3'h2,
        MODE_Z1 = 3'h3,
        MODE_Z2 = 3'h4
    } conv_mode_e;

    // conversion sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_SHIFT = 2'b11
    } conv_state_e;

    // converter input mux
    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_X_POS = 2'h1,
        SEL_Y_POS = 2'h2,
        SEL_Y_NEG = 2'h3
    } adc_sel_e;

    // plate switch enables, high closes the switch
    typedef struct packed {
        logic x_pos_supply;
        logic x_pos_pullup;
        logic x_neg_ground;
        logic y_pos_supply;
        logic y_neg_ground;
    } plate_sw_s;

    localparam plate_sw_s PLATE_OPEN = 5'h00;

    // pins from outside the clock domain
    typedef struct packed {
        logic device_reset_n;
        logic select_n;
        logic serial_clk;
        logic serial_data;
        logic key_press;
        logic touch_detect;
    } pin_in_s;

    localparam int PIN_W = 6;
    localparam pin_in_s PIN_RST = 6'h30;

endpackage : touch_pkg

// ---- hdl/pin_sync.sv ----
// pin_sync: two-flop synchroniser for a group of pins from outside the clock domain.
// assumes one reference clock; the first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // two stages, both frozen with the enable
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= RST_VAL;
            sync_out <= RST_VAL;
        end else if (en_in) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : pin_sync

`default_nettype wire

// ---- hdl/touch_panel_pin_control.sv ----
// touch_panel_pin_control: pin-level control of a resistive touch panel controller.
// assumes the host drives the serial clock and select; the converter result and
// plate switches sit on the reference clock; all pins pass a two-flop synchroniser.
`timescale 1ns/100ps
`default_nettype none

module touch_panel_pin_control #(
    parameter int DEBOUNCE_CYCLES = touch_pkg::DEBOUNCE_CYCLES_DEF
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // serial port pins
    input wire logic serial_clk_in,
    input wire logic select_n_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    // device reset pin
    input wire logic device_reset_n_in,
    // keypad and panel detectors
    input wire logic key_press_in,
    input wire logic touch_detect_in,
    // event and status pins
    output logic key_event_n_out,
    output logic touch_event_n_out,
    output logic busy_out,
    // converter and plate switches
    input wire logic [touch_pkg::ADC_BITS-1:0] adc_result_in,
    output touch_pkg::adc_sel_e adc_sel_out,
    output touch_pkg::plate_sw_s plate_sw_out
);
    import touch_pkg::*;

    localparam logic [TIMER_W-1:0] SAMPLE_LAST = TIMER_W'(SAMPLE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] CONVERT_LAST = TIMER_W'(CONVERT_CYCLES - 1);
    localparam logic [TIMER_W-1:0] PERIOD_LAST = TIMER_W'(MIN_PERIOD_CYCLES - 1);
    localparam logic [TIMER_W-1:0] DEBOUNCE_LAST = TIMER_W'(DEBOUNCE_CYCLES - 1);

    // synchronised pins
    pin_in_s pins_raw;
    pin_in_s pins;

    assign pins_raw.device_reset_n = device_reset_n_in;
    assign pins_raw.select_n = select_n_in;
    assign pins_raw.serial_clk = serial_clk_in;
    assign pins_raw.serial_data = serial_data_in;
    assign pins_raw.key_press = key_press_in;
    assign pins_raw.touch_detect = touch_detect_in;

    pin_sync #(
        .WIDTH(PIN_W),
        .RST_VAL(PIN_RST)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .en_in(clk_en_in),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // state
    logic sclk_prev;
    logic [2:0] rx_count;
    logic [CMD_BITS-2:0] rx_shift;
    logic pen_enable;
    logic key_enable;
    conv_state_e state;
    conv_state_e next_state;
    conv_mode_e mode;
    logic [TIMER_W-1:0] conv_timer;
    logic [TIMER_W-1:0] next_conv_timer;
    logic [TIMER_W-1:0] rate_timer;
    logic [ADC_BITS-1:0] result_shift;
    logic [3:0] tx_count;
    logic key_scan;
    logic [TIMER_W-1:0] key_timer;
    logic dout_bit;
    logic busy;
    logic key_event_n;
    logic touch_event_n;
    adc_sel_e adc_sel;
    plate_sw_s plate_sw;

    // edge and level decode from synchronised pins
    logic soft_rst;
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    logic [CMD_BITS-1:0] cmd_word;
    logic cmd_strobe;
    conv_mode_e cmd_mode;
    logic cmd_mode_legal;
    logic conv_start;
    logic sample_done;
    logic convert_done;
    logic tx_last;
    logic key_start;
    logic key_done;

    assign soft_rst = ~pins.device_reset_n;
    assign selected = ~pins.select_n;
    assign sclk_rise = pins.serial_clk & ~sclk_prev;
    assign sclk_fall = ~pins.serial_clk & sclk_prev;

    // command assembly: eighth rising edge under select completes a word
    assign cmd_word = {rx_shift, pins.serial_data};
    assign cmd_strobe = selected & sclk_rise & (rx_count == 3'h7);
    assign cmd_mode = conv_mode_e'(cmd_word[CMD_MODE_LSB +: 3]);
    assign cmd_mode_legal = (cmd_mode == MODE_X) | (cmd_mode == MODE_Y) |
        (cmd_mode == MODE_Z1) | (cmd_mode == MODE_Z2);

    // a start is dropped while sampling, converting or shifting, or inside the minimum period
    assign conv_start = cmd_strobe & cmd_word[CMD_START_BIT] & cmd_mode_legal &
        (state == ST_IDLE) & (rate_timer == '0);

    assign sample_done = (state == ST_SAMPLE) & (conv_timer == SAMPLE_LAST);
    assign convert_done = (state == ST_CONVERT) & (conv_timer == CONVERT_LAST);
    assign tx_last = (tx_count == 4'h0);

    // keypad debounce scan start and end
    assign key_start = key_enable & pins.key_press & ~key_scan;
    assign key_done = key_scan & (key_timer == DEBOUNCE_LAST);

    // serial clock history for edge detection
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_prev <= 1'b0;
        end else if (clk_en_in) begin
            sclk_prev <= pins.serial_clk;
        end
    end

    // command receiver; select high throws away a partial word
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_count <= 3'h0;
            rx_shift <= '0;
        end else if (clk_en_in) begin
            if (soft_rst || !selected) begin
                rx_count <= 3'h0;
                rx_shift <= '0;
            end else if (sclk_rise) begin
                rx_count <= rx_count + 3'h1;
                rx_shift <= cmd_word[CMD_BITS-2:0];
            end
        end
    end

    // interrupt enables written by any complete command
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pen_enable <= 1'b0;
            key_enable <= 1'b0;
        end else if (clk_en_in) begin
            if (soft_rst) begin
                pen_enable <= 1'b0;
                key_enable <= 1'b0;
            end else if (cmd_strobe) begin
                pen_enable <= cmd_word[CMD_PEN_EN_BIT];
                key_enable <= cmd_word[CMD_KEY_EN_BIT];
            end
        end
    end

    // conversion sequencer: sample, convert, then wait for the host clock
    always_comb begin
        next_state = state;
        next_conv_timer = conv_timer + TIMER_W'(1);
        unique case (state)
            ST_IDLE: begin
                next_conv_timer = '0;
                if (conv_start) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (sample_done) begin
                    next_state = ST_CONVERT;
                    next_conv_timer = '0;
                end
            end
            ST_CONVERT: begin
                // busy holds here until the MSB goes out
                if (convert_done) begin
                    next_conv_timer = conv_timer;
                end
                if (conv_timer == CONVERT_LAST && selected && sclk_fall) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                next_conv_timer = '0;
                if (!selected || (sclk_fall && tx_last)) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // sequencer state and timer
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            conv_timer <= '0;
        end else if (clk_en_in) begin
            state <= soft_rst ? ST_IDLE : next_state;
            conv_timer <= soft_rst ? '0 : next_conv_timer;
        end
    end

    // measurement mode taken with the start
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode <= MODE_NONE;
        end else if (clk_en_in) begin
            if (soft_rst) begin
                mode <= MODE_NONE;
            end else if (conv_start) begin
                mode <= cmd_mode;
            end
        end
    end

    // sampling period guard, counts from each start
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rate_timer <= '0;
        end else if (clk_en_in) begin
            if (soft_rst) begin
                rate_timer <= '0;
            end else if (conv_start) begin
                rate_timer <= PERIOD_LAST;
            end else if (rate_timer != '0) begin
                rate_timer <= rate_timer - TIMER_W'(1);
            end
        end
    end

    // result capture and serial output, bits move on falling edges
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_shift <= '0;
            tx_count <= 4'h0;
            dout_bit <= 1'b0;
        end else if (clk_en_in) begin
            if (soft_rst || (state == ST_SHIFT && !selected)) begin
                tx_count <= 4'h0;
                dout_bit <= 1'b0;
            end else if (state == ST_CONVERT && conv_timer == CONVERT_LAST - TIMER_W'(1)) begin
                // latched once as the timer lands on its end, so the MSB is ready for any fall
                result_shift <= adc_result_in;
            end else if (convert_done && selected && sclk_fall) begin
                // falls during the conversion itself must not move bits out early
                dout_bit <= result_shift[ADC_BITS-1];
                result_shift <= {result_shift[ADC_BITS-2:0], 1'b0};
                tx_count <= 4'(ADC_BITS - 1);
            end else if (state == ST_SHIFT && sclk_fall) begin
                dout_bit <= tx_last ? 1'b0 : result_shift[ADC_BITS-1];
                result_shift <= {result_shift[ADC_BITS-2:0], 1'b0};
                tx_count <= tx_last ? 4'h0 : tx_count - 4'h1;
            end
        end
    end

    // keypad debounce scan timer
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_scan <= 1'b0;
            key_timer <= '0;
        end else if (clk_en_in) begin
            if (soft_rst || key_done) begin
                key_scan <= 1'b0;
                key_timer <= '0;
            end else if (key_start) begin
                key_scan <= 1'b1;
                key_timer <= '0;
            end else if (key_scan) begin
                key_timer <= key_timer + TIMER_W'(1);
            end
        end
    end

    // plate switches per measurement; pen waiting only when pen interrupt is on
    plate_sw_s next_plate_sw;
    adc_sel_e next_adc_sel;
    logic measuring;
    logic pen_waiting;

    assign measuring = (state == ST_SAMPLE) | (state == ST_CONVERT);
    assign pen_waiting = ~measuring & pen_enable;

    always_comb begin
        next_plate_sw = PLATE_OPEN;
        next_adc_sel = SEL_NONE;
        if (measuring) begin
            unique case (mode)
                MODE_X: begin
                    next_plate_sw.x_pos_supply = 1'b1;
                    next_plate_sw.x_neg_ground = 1'b1;
                    next_adc_sel = SEL_Y_POS;
                end
                MODE_Y: begin
                    next_plate_sw.y_pos_supply = 1'b1;
                    next_plate_sw.y_neg_ground = 1'b1;
                    next_adc_sel = SEL_X_POS;
                end
                MODE_Z1: begin
                    next_plate_sw.x_neg_ground = 1'b1;
                    next_plate_sw.y_pos_supply = 1'b1;
                    next_adc_sel = SEL_X_POS;
                end
                MODE_Z2: begin
                    next_plate_sw.x_neg_ground = 1'b1;
                    next_plate_sw.y_pos_supply = 1'b1;
                    next_adc_sel = SEL_Y_NEG;
                end
                default: begin
                    next_plate_sw = PLATE_OPEN;
                end
            endcase
        end else if (pen_waiting) begin
            next_plate_sw.y_neg_ground = 1'b1;
            next_plate_sw.x_pos_pullup = 1'b1;
        end
    end

    // pin outputs registered so they never glitch on the panel
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            plate_sw <= PLATE_OPEN;
            adc_sel <= SEL_NONE;
            busy <= 1'b0;
            key_event_n <= 1'b1;
            touch_event_n <= 1'b1;
        end else if (clk_en_in) begin
            plate_sw <= soft_rst ? PLATE_OPEN : next_plate_sw;
            adc_sel <= soft_rst ? SEL_NONE : next_adc_sel;
            busy <= ~soft_rst & ((state == ST_CONVERT) | key_scan);
            key_event_n <= soft_rst | ~key_enable | ~key_scan;
            touch_event_n <= soft_rst | ~pen_enable | selected |
                ~pins.touch_detect;
        end
    end

    // serial output enable follows the synchronised select
    assign serial_data_oe_out = selected;
    assign serial_data_out = dout_bit;
    assign busy_out = busy;
    assign key_event_n_out = key_event_n;
    assign touch_event_n_out = touch_event_n;
    assign adc_sel_out = adc_sel;
    assign plate_sw_out = plate_sw;

endmodule : touch_panel_pin_control

`default_nettype wire

// ---- bench/touch_panel_pin_control_asserts.sv ----
// checker: port-level timing of the touch panel pin control block
// assumes one reference clock; bound to the top module at the foot of this file
`timescale 1ns/100ps
`default_nettype none

module touch_panel_pin_control_asserts #(
    parameter int DEBOUNCE_CYCLES = touch_pkg::DEBOUNCE_CYCLES_DEF
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // serial port, device reset, panel
    input wire logic serial_clk_in,
    input wire logic select_n_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out,
    input wire logic device_reset_n_in,
    input wire logic touch_detect_in,
    // events, converter and plates
    input wire logic key_event_n_out,
    input wire logic touch_event_n_out,
    input wire logic busy_out,
    input wire touch_pkg::adc_sel_e adc_sel_out,
    input wire touch_pkg::plate_sw_s plate_sw_out
);
    import touch_pkg::*;
    logic sclk_q;
    logic [3:0] fall_age;
    logic [16:0] klen;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // age since the serial clock pin fell, saturating so an idle link stays quiet
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_q <= 1'b0;
            fall_age <= 4'hF;
            klen <= 17'h00000;
        end else begin
            sclk_q <= serial_clk_in;
            fall_age <= (sclk_q && !serial_clk_in) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
            klen <= key_event_n_out ? 17'h00000 : klen + 17'h00001;
        end
    end

    // a key scan starts with the key event falling while busy is high
    sequence s_key_start;
        $fell(key_event_n_out) ##0 busy_out;
    endsequence
    property p_hiz; select_n_in[*3] |-> !serial_data_oe_out; endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while deselected");
    property p_dout_edge; $changed(serial_data_out) && serial_data_oe_out |-> fall_age inside {[1:7]}; endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("output bit moved off a falling clock");
    property p_busy_msb; $fell(busy_out) && $past(key_event_n_out) && device_reset_n_in |-> fall_age inside {[1:7]}; endproperty
    a_busy_msb: assert property (p_busy_msb) else $error("busy ended away from the first bit");
    property p_key_busy; s_key_start |-> (busy_out && !key_event_n_out)[*8]; endproperty
    a_key_busy: assert property (p_key_busy) else $error("key scan cut short");
    property p_key_len; $rose(key_event_n_out) && device_reset_n_in |-> klen inside {[DEBOUNCE_CYCLES-1:DEBOUNCE_CYCLES+1]}; endproperty
    a_key_len: assert property (p_key_len) else $error("key scan length wrong");
    property p_pen_sel; (!select_n_in)[*4] |-> touch_event_n_out; endproperty
    a_pen_sel: assert property (p_pen_sel) else $error("pen event while selected");
    property p_pen_touch; (!touch_detect_in)[*4] |-> touch_event_n_out; endproperty
    a_pen_touch: assert property (p_pen_touch) else $error("pen event without touch");
    property p_dev_rst; (!device_reset_n_in)[*5] |-> !busy_out && key_event_n_out && touch_event_n_out && plate_sw_out == PLATE_OPEN; endproperty
    a_dev_rst: assert property (p_dev_rst) else $error("device reset not applied");
    property p_plate_x; adc_sel_out == SEL_Y_POS |-> plate_sw_out == 5'h14; endproperty
    a_plate_x: assert property (p_plate_x) else $error("x plates wrong");
    property p_plate_y; adc_sel_out == SEL_X_POS && plate_sw_out.y_neg_ground |-> plate_sw_out == 5'h03; endproperty
    a_plate_y: assert property (p_plate_y) else $error("y plates wrong");
    property p_plate_z; adc_sel_out == SEL_Y_NEG || (adc_sel_out == SEL_X_POS && !plate_sw_out.y_neg_ground) |-> plate_sw_out == 5'h06; endproperty
    a_plate_z: assert property (p_plate_z) else $error("pressure plates wrong");
endmodule : touch_panel_pin_control_asserts

bind touch_panel_pin_control touch_panel_pin_control_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in),
    .select_n_in(select_n_in), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .device_reset_n_in(device_reset_n_in),
    .touch_detect_in(touch_detect_in), .key_event_n_out(key_event_n_out),
    .touch_event_n_out(touch_event_n_out), .busy_out(busy_out),
    .adc_sel_out(adc_sel_out), .plate_sw_out(plate_sw_out)
);

`default_nettype wire

// ---- bench/touch_host_model.sv ----
// host model: clocks commands into the serial port and results back out
// assumes the bench resolves the released data line before miso_in
`timescale 1ns/100ps
`default_nettype none

module touch_host_model (
    // serial port, host side
    output logic sclk_out,
    output logic sel_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    localparam int HALF = 200;
    logic [15:0] rd_word;
    event got;

    // link clock stands still low between frames
    initial begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        mosi_out = 1'b0;
        rd_word = 16'h0000;
    end

    // one bit: data set on the low phase, result taken at the rising edge
    task automatic clk_bit(input logic b, output logic r);
        mosi_out = b;
        #HALF;
        r = miso_in;
        sclk_out = 1'b1;
        #HALF;
        sclk_out = 1'b0;
    endtask : clk_bit

    // nb command bits msb first, then nrd bits read after the conversion time
    task automatic frame(input logic [7:0] cmd, input int nb, input int nrd);
        logic r;
        sel_n_out = 1'b0;
        #HALF;
        for (int i = 7; i > 7 - nb; i--) clk_bit(cmd[i], r);
        mosi_out = 1'b0;
        rd_word = 16'h0000;
        if (nrd > 0) #6000;
        for (int i = 0; i < nrd; i++) begin
            clk_bit(1'b0, r);
            rd_word = {rd_word[14:0], r};
        end
        if (nrd > 0) -> got;
        #HALF;
        sel_n_out = 1'b1;
        #HALF;
    endtask : frame

    // select held without clocks
    task automatic set_sel(input logic v);
        sel_n_out = v;
    endtask : set_sel
endmodule : touch_host_model

`default_nettype wire

// ---- bench/touch_panel_pin_control_test.sv ----
// bench: conversions, pen and key events, device reset and command abort
// assumes the host model on the serial pins and the checker bound from its file
`timescale 1ns/100ps
`default_nettype none

module touch_panel_pin_control_test;
    import touch_pkg::*;
    localparam int DEB = 20;
    localparam logic [4:0] SW_EXP [1:4] = '{5'h14, 5'h03, 5'h06, 5'h06};
    localparam logic [1:0] SEL_EXP [1:4] = '{2'h2, 2'h1, 2'h1, 2'h3};
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic dev_rst_n = 1'b1;
    logic key = 1'b0;
    logic touch = 1'b0;
    logic [11:0] adc = 12'h000;
    logic sclk, sel_n, mosi, sd_line, dout, oe, key_n, touch_n, busy;
    adc_sel_e sel;
    plate_sw_s sw;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [15:0] exp_q[$];

    always #25 ref_clk_in = ~ref_clk_in;
    // a released line shows the inverse so a stale level never reads as data
    assign sd_line = oe ? dout : ~dout;

    touch_panel_pin_control #(.DEBOUNCE_CYCLES(DEB)) dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .serial_clk_in(sclk), .select_n_in(sel_n), .serial_data_in(mosi),
        .serial_data_out(dout), .serial_data_oe_out(oe), .device_reset_n_in(dev_rst_n),
        .key_press_in(key), .touch_detect_in(touch), .key_event_n_out(key_n),
        .touch_event_n_out(touch_n), .busy_out(busy), .adc_result_in(adc),
        .adc_sel_out(sel), .plate_sw_out(sw)
    );

    touch_host_model host (
        .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi), .miso_in(sd_line)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step

    // bounded wait on the key event level; running out ends the run
    task automatic wait_key(input logic v);
        int i;
        for (i = 0; i < 200 && key_n !== v; i++) step(1);
        if (i == 200) begin
            n_mismatch++;
            results();
        end
    endtask : wait_key

    // oldest expected word against each word the host reads back
    always begin
        @(host.got);
        chk(host.rd_word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD);
    end

    initial begin
        void'($urandom(92351));
        step(3);
        rst_in = 1'b0;
        step(3);
        chk({oe, busy, key_n, touch_n, 7'h00, sw}, 16'h3000);
        // every measurement mode, random converter value, plates mid-conversion
        for (int m = 1; m <= 4; m++) begin
            adc = 12'($urandom);
            exp_q.push_back({3'b000, adc, 1'b0});
            fork
                host.frame({1'b1, 3'(m), 4'h0}, 8, 14);
                begin
                    step(140);
                    chk(16'(sw), 16'(SW_EXP[m]));
                    chk(16'(sel), 16'(SEL_EXP[m]));
                    chk(16'(busy), 16'h0001);
                end
            join
            step(10);
        end
        // pen waiting, then touch seen only while deselected
        host.frame(8'h08, 8, 0);
        step(6);
        chk(16'(sw), 16'h0009);
        touch = 1'b1;
        step(5);
        chk(16'(touch_n), 16'h0000);
        host.set_sel(1'b0);
        step(5);
        chk(16'(touch_n), 16'h0001);
        host.set_sel(1'b1);
        // device reset clears the enables, so touch stays unreported after
        dev_rst_n = 1'b0;
        step(6);
        chk({10'h000, touch_n, sw}, 16'h0020);
        dev_rst_n = 1'b1;
        step(8);
        chk({10'h000, touch_n, sw}, 16'h0020);
        touch = 1'b0;
        // a dropped partial word must not shift the next command
        host.frame(8'h00, 5, 0);
        host.frame(8'h08, 8, 0);
        step(6);
        chk(16'(sw), 16'h0009);
        // key scan with key events on, then none with them off
        host.frame(8'h04, 8, 0);
        key = 1'b1;
        wait_key(1'b0);
        chk(16'(busy), 16'h0001);
        key = 1'b0;
        wait_key(1'b1);
        chk(16'(busy), 16'h0000);
        host.frame(8'h00, 8, 0);
        key = 1'b1;
        step(30);
        chk(16'(key_n), 16'h0001);
        key = 1'b0;
        step(20);
        chk(16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule : touch_panel_pin_control_test

`default_nettype wire
